// ===== core/qcnt_pkg.sv
// Purpose: shared constants and types for the two-phase event counter
// Assumes: one 100 MHz clock, Avalon-MM slave with 32-bit data
// Notes: channel 0..2 stand for the second, third and fourth timers
package qcnt_pkg;
	// channel count, bus address width and counter width
	localparam int NCH = 3;
	localparam int AW = 6;
	localparam int CW = 16;

	// byte offsets of the register words
	localparam logic [5:0] OFS_START = 6'h00;
	localparam logic [5:0] OFS_STAT = 6'h04;
	localparam logic [5:0] OFS_MASK = 6'h08;
	localparam logic [5:0] OFS_TMR0 = 6'h10;
	localparam logic [5:0] OFS_MODE0 = 6'h14;
	localparam logic [5:0] CH_STRIDE = 6'h08;

	// counter limits and reset values
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [2:0] FLAG_RST = 3'h0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// operation mode field value for event counting
	localparam logic [1:0] OPMODE_EVENT = 2'h1;

	// per-channel processing options: fixed x4, or selectable
	localparam logic [2:0] X4_FIXED = 3'h4;
	localparam logic [2:0] X4_CHOICE = 3'h2;

	// channel mode register layout
	typedef struct packed {
		logic quad_x4_sel;
		logic reload_or_freerun_sel;
		logic [3:0] rsvd;
		logic op_mode_sel_hi;
		logic op_mode_sel_lo;
	} mode_s;

	// one decoded counting step
	typedef struct packed {
		logic ev;
		logic up;
	} step_s;

	// bus answer sequencing
	typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage

// ===== core/qcnt_top.sv
// Purpose: three-channel 16-bit two-phase (quadrature) event counter
// Assumes: pins are phase inputs from an encoder; the ports are fixed inputs
// Notes: every answer on the bus takes exactly two clock edges
`timescale 1ns/100ps

module qcnt_top import qcnt_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [AW-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// encoder phase pins, one per channel
	input wire logic [NCH-1:0] phase_a_input_pin,
	input wire logic [NCH-1:0] phase_b_input_pin,
	// interrupt
	output logic irq
);

	// byte offset of a per-channel register
	function automatic logic [5:0] ch_ofs(input logic [5:0] base,
		input int ch);
		ch_ofs = base + 6'(ch) * CH_STRIDE;
	endfunction

	// decode one step from current and previous phase levels
	function automatic step_s step_f(input logic a, input logic ap,
		input logic b, input logic bp, input logic x4);
		step_s s;
		s = '0;
		if (x4) begin
			// exactly one pin toggled; B level vs old A gives direction
			s.ev = (a ^ ap) ^ (b ^ bp);
			s.up = ap ^ b;
		end else begin
			// only A edges count, and only while B is high
			s.ev = b & (a ^ ap);
			s.up = a;
		end
		step_f = s;
	endfunction

	bus_state_e state_q;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic [31:0] rd_mux;
	logic bus_wr;
	logic [NCH-1:0] start_q, stat_q, mask_q, irq_stat_d, mask_d;
	logic irq_q;
	logic [NCH-1:0] a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
	mode_s mode_q [NCH];
	logic [CW-1:0] cnt_q [NCH];
	logic [CW-1:0] reload_q [NCH];
	logic [NCH-1:0] wr_tmr, wr_mode, run, ev, up, wrap, x4_eff;

	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;
	assign irq = irq_q;
	// a write takes effect only at the edge where waitrequest is low
	assign bus_wr = write & (state_q == BUS_ANSWER);

	// bus handshake: one wait cycle, then the answer for one cycle
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q <= BUS_IDLE;
			waitrequest_q <= 1'b1;
			readdata_q <= RD_ZERO;
		end else begin
			case (state_q)
				BUS_IDLE: begin
					if (read | write) begin
						state_q <= BUS_ANSWER;
						waitrequest_q <= 1'b0;
						readdata_q <= read ? rd_mux : RD_ZERO;
					end
				end
				default: begin
					state_q <= BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
			endcase
		end
	end

	// read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = RD_ZERO;
		if (address == OFS_START) begin
			rd_mux[NCH-1:0] = start_q;
		end else if (address == OFS_STAT) begin
			rd_mux[NCH-1:0] = stat_q;
		end else if (address == OFS_MASK) begin
			rd_mux[NCH-1:0] = mask_q;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (address == ch_ofs(OFS_TMR0, c)) begin
					rd_mux[CW-1:0] = cnt_q[c];
				end else if (address == ch_ofs(OFS_MODE0, c)) begin
					rd_mux[7:0] = mode_q[c];
				end
			end
		end
	end

	// per-channel write strobes
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			wr_tmr[c] = bus_wr && (address == ch_ofs(OFS_TMR0, c));
			wr_mode[c] = bus_wr && (address == ch_ofs(OFS_MODE0, c));
		end
	end

	// start flags: a clear stops the channel from the next edge on
	always_ff @(posedge clock) begin
		if (!rstn) begin
			start_q <= FLAG_RST;
		end else if (bus_wr && address == OFS_START) begin
			start_q <= writedata[NCH-1:0];
		end
	end

	// channel mode registers; reserved bits kept at zero
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int c = 0; c < NCH; c++) begin
				mode_q[c] <= MODE_RST;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_mode[c]) begin
					mode_q[c] <= writedata[7:0] & 8'hc3;
				end
			end
		end
	end

	// pin synchronisers; stage 3 holds the previous level for edges
	always_ff @(posedge clock) begin
		if (!rstn) begin
			a_s1 <= FLAG_RST;
			a_s2 <= FLAG_RST;
			a_s3 <= FLAG_RST;
			b_s1 <= FLAG_RST;
			b_s2 <= FLAG_RST;
			b_s3 <= FLAG_RST;
		end else begin
			a_s1 <= phase_a_input_pin;
			a_s2 <= a_s1;
			a_s3 <= a_s2;
			b_s1 <= phase_b_input_pin;
			b_s2 <= b_s1;
			b_s3 <= b_s2;
		end
	end

	// step decode; a channel runs only in event mode with start set
	always_comb begin
		step_s st;
		st = '0;
		for (int c = 0; c < NCH; c++) begin
			// fixed channels ignore the select bit
			x4_eff[c] = X4_FIXED[c] |
				(X4_CHOICE[c] & mode_q[c].quad_x4_sel);
			st = step_f(a_s2[c], a_s3[c], b_s2[c], b_s3[c], x4_eff[c]);
			run[c] = start_q[c] && ({mode_q[c].op_mode_sel_hi,
				mode_q[c].op_mode_sel_lo} == OPMODE_EVENT);
			ev[c] = run[c] & st.ev;
			up[c] = st.up;
			wrap[c] = ev[c] && (up[c] ? (cnt_q[c] == CNT_MAX) :
				(cnt_q[c] == CNT_RST));
		end
	end

	// counter and reload; a write never meets a step (stopped vs running)
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int c = 0; c < NCH; c++) begin
				cnt_q[c] <= CNT_RST;
				reload_q[c] <= CNT_RST;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_tmr[c]) begin
					reload_q[c] <= writedata[CW-1:0];
					if (!start_q[c]) begin
						cnt_q[c] <= writedata[CW-1:0];
					end
				end
				if (ev[c]) begin
					if (wrap[c] && !mode_q[c].reload_or_freerun_sel) begin
						cnt_q[c] <= reload_q[c];
					end else if (up[c]) begin
						cnt_q[c] <= cnt_q[c] + 16'h0001;
					end else begin
						cnt_q[c] <= cnt_q[c] - 16'h0001;
					end
				end
			end
		end
	end

	// sticky status, write one to clear; a new wrap beats the clear
	always_comb begin
		irq_stat_d = stat_q;
		mask_d = mask_q;
		if (bus_wr && address == OFS_STAT) begin
			irq_stat_d = stat_q & ~writedata[NCH-1:0];
		end
		if (bus_wr && address == OFS_MASK) begin
			mask_d = writedata[NCH-1:0];
		end
		irq_stat_d = irq_stat_d | wrap;
	end

	// status, mask and the level interrupt, all registered
	always_ff @(posedge clock) begin
		if (!rstn) begin
			stat_q <= FLAG_RST;
			mask_q <= FLAG_RST;
			irq_q <= 1'b0;
		end else begin
			stat_q <= irq_stat_d;
			mask_q <= mask_d;
			irq_q <= |(irq_stat_d & mask_d);
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	property p_stop_holds;
		!start_q[1] && !wr_tmr[1] |=> $stable(cnt_q[1]);
	endproperty
	a_stop_holds: assert property (p_stop_holds)
		else $error("counter moved while stopped");

	// a mask write in the wrap cycle may legally keep the line low
	property p_wrap_irq;
		wrap[1] && mask_q[1] && !(bus_wr && address == OFS_MASK)
			|=> irq && stat_q[1];
	endproperty
	a_wrap_irq: assert property (p_wrap_irq)
		else $error("wrap did not raise interrupt");

	property p_reload;
		wrap[1] && !mode_q[1].reload_or_freerun_sel
			|=> cnt_q[1] == $past(reload_q[1]);
	endproperty
	a_reload: assert property (p_reload)
		else $error("no reload on wrap");

	property p_freerun;
		wrap[1] && up[1] && mode_q[1].reload_or_freerun_sel
			|=> cnt_q[1] == CNT_RST;
	endproperty
	a_freerun: assert property (p_freerun)
		else $error("free-run did not wrap to zero");

	property p_wr_stopped;
		wr_tmr[0] && !start_q[0] |=> cnt_q[0] == $past(writedata[15:0])
			&& reload_q[0] == cnt_q[0];
	endproperty
	a_wr_stopped: assert property (p_wr_stopped)
		else $error("stopped write did not load counter");

	property p_wr_running;
		wr_tmr[0] && start_q[0] && !ev[0] |=> $stable(cnt_q[0]);
	endproperty
	a_wr_running: assert property (p_wr_running)
		else $error("running write changed counter");

	property p_normal_up;
		run[0] && b_s2[0] && a_s2[0] && !a_s3[0] && cnt_q[0] != CNT_MAX
			|=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001;
	endproperty
	a_normal_up: assert property (p_normal_up)
		else $error("normal mode missed up count");

	property p_normal_b_ignored;
		run[0] && (b_s2[0] != b_s3[0]) && (a_s2[0] == a_s3[0])
			|=> $stable(cnt_q[0]);
	endproperty
	a_normal_b_ignored: assert property (p_normal_b_ignored)
		else $error("normal channel counted a B edge");

	property p_x4_b_counts;
		run[2] && (b_s2[2] != b_s3[2]) && (a_s2[2] == a_s3[2])
			&& !wrap[2] |=> cnt_q[2] != $past(cnt_q[2]);
	endproperty
	a_x4_b_counts: assert property (p_x4_b_counts)
		else $error("x4 channel ignored a B edge");

	property p_normal_down;
		run[0] && b_s2[0] && !a_s2[0] && a_s3[0] && cnt_q[0] != CNT_RST
			|=> cnt_q[0] == $past(cnt_q[0]) - 16'h0001;
	endproperty
	a_normal_down: assert property (p_normal_down)
		else $error("normal mode missed down count");

	// A falling under a steady high B is a down step on the x4 channel
	property p_x4_down;
		run[2] && b_s2[2] && b_s3[2] && !a_s2[2] && a_s3[2]
			&& cnt_q[2] != CNT_RST
			|=> cnt_q[2] == $past(cnt_q[2]) - 16'h0001;
	endproperty
	a_x4_down: assert property (p_x4_down)
		else $error("x4 channel missed down count");

	// outside event mode the pins must never move the counter
	property p_mode_gate;
		{mode_q[0].op_mode_sel_hi, mode_q[0].op_mode_sel_lo} != OPMODE_EVENT
			&& !wr_tmr[0] |=> $stable(cnt_q[0]);
	endproperty
	a_mode_gate: assert property (p_mode_gate)
		else $error("counter moved outside event mode");

	property p_read_cnt;
		read && !write && state_q == BUS_IDLE && address == OFS_TMR0
			|=> readdata[15:0] == $past(cnt_q[0]) ##1 waitrequest;
	endproperty
	a_read_cnt: assert property (p_read_cnt)
		else $error("timer read returned wrong value");

	c_overflow: cover property (wrap[1] && up[1]);
	c_underflow_x4: cover property (wrap[2] && !up[2]);
	c_irq: cover property (irq);
	c_wr_running: cover property (wr_tmr[1] && start_q[1]);
endmodule

// ===== tb/enc_model.sv
// Purpose: quadrature encoder model that drives the phase pins
// Assumes: pins change just after a rising clock edge
// Notes: a pin that is not moving holds its level, as a real encoder does
`timescale 1ns/100ps
module enc_model (
	// clock
	input wire logic clock,
	// phase pins, pure inputs of the counter
	output logic [2:0] pa,
	output logic [2:0] pb
);
	int pos [3];

	// rest position (a,b)=01, so b is high out of reset
	initial begin
		pa = 3'h0;
		pb = 3'h7;
		pos = '{0, 0, 0};
	end

	// one quarter step; only one pin moves, then it holds gap more cycles
	// up order (a,b): 01 11 10 00, which puts an a rise under b high
	task automatic step(input int ch, input bit up, input int gap);
		pos[ch] = up ? (pos[ch] + 1) % 4 : (pos[ch] + 3) % 4;
		@(posedge clock);
		pa[ch] <= (pos[ch] == 1 || pos[ch] == 2);
		pb[ch] <= (pos[ch] < 2);
		repeat (gap) @(posedge clock);
	endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the two-phase event counter
// Assumes: encoder model on the pins, registers over avalon-mm
// Notes: counts are read only after pins settle through the sync stages
`timescale 1ns/100ps
module tb_top import qcnt_pkg::*;;
	logic clock, rstn, read, write, irq, waitrequest;
	logic [5:0] address;
	logic [31:0] writedata, readdata, q;
	logic [2:0] pa, pb;
	int miscompares, total_checks;
	localparam logic [5:0] tmr1 = 6'(OFS_TMR0 + CH_STRIDE);
	localparam logic [5:0] tmr2 = 6'(OFS_TMR0 + 2 * CH_STRIDE);
	localparam logic [5:0] mode1 = 6'(OFS_MODE0 + CH_STRIDE);
	localparam logic [5:0] mode2 = 6'(OFS_MODE0 + 2 * CH_STRIDE);

	qcnt_top dut_u (.clock(clock), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.phase_a_input_pin(pa), .phase_b_input_pin(pb), .irq(irq));
	enc_model enc_u (.clock(clock), .pa(pa), .pb(pb));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// closing report, shared by the main sequence and the watchdog
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one bus cycle; held until waitrequest is seen low, no fixed latency
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge clock);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	// irq is registered alongside status and mask, so let it land first
	task automatic irqchk(input logic e);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	// n quarter steps, then wait out the synchroniser before any read
	task automatic mv(input int ch, input int n, input bit up, input int gap);
		repeat (n) enc_u.step(ch, up, gap);
		repeat (6) @(posedge clock);
	endtask

	task automatic t_reset();
		rd(OFS_START, 32'h0);
		rd(OFS_STAT, 32'h0);
		rd(OFS_MASK, 32'h0);
		rd(OFS_MODE0, 32'h0);
		rd(tmr2, 32'h0);
		wr(6'h3c, 32'h5a);
		rd(6'h3c, 32'h0);
		irqchk(1'b0);
		$display("done reset");
	endtask

	// channel 0: one count per a rise (up) or a fall (down) under b high
	task automatic t_normal();
		wr(OFS_MODE0, 32'h01);
		wr(OFS_TMR0, 32'h1234);
		rd(OFS_TMR0, 32'h1234);
		wr(OFS_START, 32'h1);
		mv(0, 12, 1'b1, 1);
		rd(OFS_TMR0, 32'h1237);
		mv(0, 4, 1'b0, 4);
		rd(OFS_TMR0, 32'h1236);
		wr(OFS_START, 32'h0);
		mv(0, 4, 1'b1, 1);
		rd(OFS_TMR0, 32'h1236);
		// started, but the mode field is not event counting
		wr(OFS_MODE0, 32'h00);
		wr(OFS_START, 32'h1);
		mv(0, 4, 1'b1, 1);
		rd(OFS_TMR0, 32'h1236);
		$display("done normal");
	endtask

	// channel 2 is x4 with the select bit clear; channel 1 then is normal
	task automatic t_x4();
		wr(mode2, 32'h01);
		wr(mode1, 32'h01);
		wr(tmr2, 32'h10);
		wr(tmr1, 32'h10);
		wr(OFS_START, 32'h6);
		mv(2, 5, 1'b1, 1);
		mv(1, 4, 1'b1, 1);
		rd(tmr2, 32'h15);
		rd(tmr1, 32'h11);
		mv(2, 3, 1'b0, 4);
		rd(tmr2, 32'h12);
		$display("done x4");
	endtask

	// reload type: running write reaches only the reload register
	task automatic t_reload();
		wr(OFS_START, 32'h0);
		wr(tmr2, 32'hfffd);
		wr(OFS_START, 32'h4);
		wr(tmr2, 32'h5);
		rd(tmr2, 32'hfffd);
		wr(OFS_STAT, 32'h7);
		mv(2, 2, 1'b1, 1);
		rd(OFS_STAT, 32'h0);
		mv(2, 1, 1'b1, 1);
		rd(tmr2, 32'h5);
		rd(OFS_STAT, 32'h4);
		wr(OFS_STAT, 32'h4);
		mv(2, 5, 1'b0, 1);
		rd(tmr2, 32'h0);
		rd(OFS_STAT, 32'h0);
		mv(2, 1, 1'b0, 1);
		rd(tmr2, 32'h5);
		rd(OFS_STAT, 32'h4);
		$display("done reload");
	endtask

	// free-run x4 on channel 1 wraps through zero; irq masked, then not
	task automatic t_free();
		wr(OFS_STAT, 32'h7);
		wr(OFS_START, 32'h0);
		wr(mode1, 32'hc1);
		wr(tmr1, 32'hfffe);
		wr(OFS_START, 32'h2);
		mv(1, 3, 1'b1, 4);
		rd(tmr1, 32'h1);
		rd(OFS_STAT, 32'h2);
		irqchk(1'b0);
		wr(OFS_MASK, 32'h2);
		irqchk(1'b1);
		wr(OFS_STAT, 32'h2);
		irqchk(1'b0);
		rd(OFS_STAT, 32'h0);
		// running write, then an underflow with the mask already open
		wr(tmr1, 32'h7);
		rd(tmr1, 32'h1);
		rd(mode1, 32'hc1);
		mv(1, 2, 1'b0, 1);
		rd(tmr1, 32'hffff);
		rd(OFS_STAT, 32'h2);
		irqchk(1'b1);
		$display("done free-run");
	endtask

	// a reset in mid-run clears every register and drops the interrupt
	task automatic t_midreset();
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		chk({31'h0, irq}, 32'h0);
		rd(OFS_START, 32'h0);
		rd(OFS_STAT, 32'h0);
		rd(OFS_MASK, 32'h0);
		rd(mode1, 32'h0);
		rd(tmr1, 32'h0);
		$display("done mid-run reset");
	endtask

	// watchdog, far beyond the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		finish_test();
	end

	// reset for 12 cycles, then the scenarios in order
	initial begin
		rstn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		writedata = 32'h0;
		miscompares = 0;
		total_checks = 0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		t_reset();
		t_normal();
		t_x4();
		t_reload();
		t_free();
		t_midreset();
		finish_test();
	end
endmodule
